//--- design/tmr16_pkg.sv
// ==========================================================
// shared constants and types of the 16-bit timer slice
// ==========================================================
package tmr16_pkg;

  // register index on the 8-bit i/o bus
  localparam logic [3:0] TMR16_A_CTRL_B = 4'h0;
  localparam logic [3:0] TMR16_A_CNT_L = 4'h1;
  localparam logic [3:0] TMR16_A_CNT_H = 4'h2;
  localparam logic [3:0] TMR16_A_CMPA_L = 4'h3;
  localparam logic [3:0] TMR16_A_CMPA_H = 4'h4;
  localparam logic [3:0] TMR16_A_CMPB_L = 4'h5;
  localparam logic [3:0] TMR16_A_CMPB_H = 4'h6;
  localparam logic [3:0] TMR16_A_CAP_L = 4'h7;
  localparam logic [3:0] TMR16_A_CAP_H = 4'h8;
  localparam logic [3:0] TMR16_A_IRQ_EN = 4'h9;
  localparam logic [3:0] TMR16_A_IRQ_FLG = 4'hA;

  // control register b fields
  localparam int TMR16_B_FILT = 7;
  localparam int TMR16_B_EDGE = 6;
  localparam int TMR16_B_WM3 = 4;
  localparam int TMR16_B_WM2 = 3;
  localparam logic [7:0] TMR16_CTRL_B_WMASK = 8'hDF;
  localparam logic [7:0] TMR16_CTRL_B_RST = 8'h00;

  // enable and flag bit positions (same in both registers)
  localparam int TMR16_BIT_CAP = 5;
  localparam int TMR16_BIT_CMPA = 4;
  localparam int TMR16_BIT_CMPB = 3;
  localparam int TMR16_BIT_OVF = 2;

  // clock select codes
  localparam logic [2:0] TMR16_CS_STOP = 3'h0;
  localparam logic [2:0] TMR16_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMR16_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMR16_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMR16_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMR16_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TMR16_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR16_CS_EXT_RISE = 3'h7;

  // fixed top values and limits
  localparam logic [15:0] TMR16_TOP_8B = 16'h00FF;
  localparam logic [15:0] TMR16_TOP_9B = 16'h01FF;
  localparam logic [15:0] TMR16_TOP_10B = 16'h03FF;
  localparam logic [15:0] TMR16_MAX = 16'hFFFF;
  localparam logic [15:0] TMR16_BOTTOM = 16'h0000;
  localparam logic [15:0] TMR16_ONE = 16'h0001;
  localparam int TMR16_FILT_LEN = 4;

  // one flag per timer event
  typedef struct packed {
    logic capture;
    logic compare_a;
    logic compare_b;
    logic overflow;
  } tmr16_evt_s;

  // counting direction
  typedef enum logic [1:0] {
    TMR16_DIR_UP = 2'b01,
    TMR16_DIR_DOWN = 2'b10
  } tmr16_dir_e;

endpackage : tmr16_pkg

//--- design/tmr16_prescale.sv
`timescale 1ns/1ps
// ==========================================================
// prescaler and clock select: one-cycle count enables
// ==========================================================
module tmr16_prescale
  import tmr16_pkg::*;
#(
  parameter int PRE_W = 10
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] clk_sel,
  input wire logic ext_count_pin,
  output logic count_en
);

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [2:0] ext_sync_r;
  logic tap;

  // free-running prescaler, tap on wrap of each stage
  assign pre_nxt = pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pre_r <= '0;
    else
      pre_r <= pre_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ext_sync_r <= 3'h0;
    else
      ext_sync_r <= {ext_sync_r[1:0], ext_count_pin};
  end

  always_comb
  begin
    tap = 1'b0;
    case (clk_sel)
      TMR16_CS_STOP: tap = 1'b0;
      TMR16_CS_DIV1: tap = 1'b1;
      TMR16_CS_DIV8: tap = &pre_r[2:0];
      TMR16_CS_DIV64: tap = &pre_r[5:0];
      TMR16_CS_DIV256: tap = &pre_r[7:0];
      TMR16_CS_DIV1024: tap = &pre_r[9:0];
      // pin edges count whatever the pin direction
      TMR16_CS_EXT_FALL: tap = ext_sync_r[2] & ~ext_sync_r[1];
      TMR16_CS_EXT_RISE: tap = ~ext_sync_r[2] & ext_sync_r[1];
      default: tap = 1'b0;
    endcase
  end

  assign count_en = tap;

endmodule : tmr16_prescale

//--- design/tmr16_capture_in.sv
`timescale 1ns/1ps
// ==========================================================
// capture input: sync, noise filter, edge select
// ==========================================================
module tmr16_capture_in
  import tmr16_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic use_comparator,
  input wire logic capture_filter_en,
  input wire logic capture_edge_sel,
  output logic edge_pulse
);

  logic [1:0] pin_sync_r;
  logic [TMR16_FILT_LEN-2:0] hist_r;
  logic filt_r;
  logic prev_r;
  logic src;
  logic level;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pin_sync_r <= 2'h0;
    else
      pin_sync_r <= {pin_sync_r[0], capture_pin};
  end

  assign src = use_comparator ? comparator_out : pin_sync_r[1];

  // four equal samples change the output
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      hist_r <= '0;
      filt_r <= 1'b0;
    end
    else
    begin
      hist_r <= {hist_r[TMR16_FILT_LEN-3:0], src};
      if (&{hist_r, src})
        filt_r <= 1'b1;
      else if (~|{hist_r, src})
        filt_r <= 1'b0;
    end
  end

  assign level = capture_filter_en ? filt_r : src;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      prev_r <= 1'b0;
    else
      prev_r <= level;
  end

  assign edge_pulse = capture_edge_sel ? (level & ~prev_r) : (~level & prev_r);

endmodule : tmr16_capture_in

//--- design/tmr16_core.sv
`timescale 1ns/1ps
// ==========================================================
// ==========================================================
module tmr16_core
  import tmr16_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [1:0] wave_mode_lo,
  input wire logic global_irq_en,
  input wire tmr16_evt_s irq_ack,
  input wire logic force_compare_a,
  input wire logic force_compare_b,
  input wire logic ext_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic use_comparator,
  output tmr16_evt_s irq_req,
  output logic compare_a_match,
  output logic compare_b_match
);

  // ==========================================================
  // registers
  // ==========================================================
  logic [7:0] timer_ctrl_b_r;
  logic [15:0] counter_value_r;
  logic [15:0] counter_value_nxt;
  logic [15:0] compare_a_value_r;
  logic [15:0] compare_b_value_r;
  logic [15:0] capture_value_r;
  logic [7:0] timer_irq_enable_r;
  tmr16_evt_s flags_r;
  tmr16_evt_s flags_nxt;
  logic [7:0] temp_r;
  logic [7:0] io_rdata_r;
  tmr16_evt_s irq_req_r;
  logic compare_a_match_r;
  logic compare_b_match_r;
  logic block_cmp_r;
  tmr16_dir_e dir_r;
  tmr16_dir_e dir_nxt;

  // ==========================================================
  // decode
  // ==========================================================
  logic [3:0] wave_mode;
  logic [15:0] top_val;
  logic phase_mode;
  logic fast_mode;
  logic cap_is_top;
  logic tick;
  logic cap_edge;
  logic wr_cnt;
  logic at_top;
  logic at_bottom;
  logic ovf_evt;
  logic cap_evt;
  logic match_a;
  logic match_b;
  logic [7:0] flags_rd;

  assign wave_mode = {timer_ctrl_b_r[TMR16_B_WM3], timer_ctrl_b_r[TMR16_B_WM2], wave_mode_lo};

  // top source and counting style per waveform mode
  always_comb
  begin
    top_val = TMR16_MAX;
    phase_mode = 1'b0;
    fast_mode = 1'b0;
    cap_is_top = 1'b0;
    case (wave_mode)
      4'd1: begin top_val = TMR16_TOP_8B; phase_mode = 1'b1; end
      4'd2: begin top_val = TMR16_TOP_9B; phase_mode = 1'b1; end
      4'd3: begin top_val = TMR16_TOP_10B; phase_mode = 1'b1; end
      4'd4: top_val = compare_a_value_r;
      4'd5: begin top_val = TMR16_TOP_8B; fast_mode = 1'b1; end
      4'd6: begin top_val = TMR16_TOP_9B; fast_mode = 1'b1; end
      4'd7: begin top_val = TMR16_TOP_10B; fast_mode = 1'b1; end
      4'd8, 4'd10:
      begin
        top_val = capture_value_r;
        phase_mode = 1'b1;
        cap_is_top = 1'b1;
      end
      4'd9, 4'd11:
      begin
        top_val = compare_a_value_r;
        phase_mode = 1'b1;
      end
      4'd12: begin top_val = capture_value_r; cap_is_top = 1'b1; end
      4'd14:
      begin
        top_val = capture_value_r;
        fast_mode = 1'b1;
        cap_is_top = 1'b1;
      end
      4'd15: begin top_val = compare_a_value_r; fast_mode = 1'b1; end
      default: top_val = TMR16_MAX;
    endcase
  end

  // ==========================================================
  // clock source and capture input
  // ==========================================================
  tmr16_prescale #(
    .PRE_W(10)
  ) u_prescale (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_sel(timer_ctrl_b_r[2:0]),
    .ext_count_pin(ext_count_pin),
    .count_en(tick)
  );

  tmr16_capture_in u_capture (
    .mclk(mclk),
    .rst_n(rst_n),
    .capture_pin(capture_pin),
    .comparator_out(comparator_out),
    .use_comparator(use_comparator),
    .capture_filter_en(timer_ctrl_b_r[TMR16_B_FILT]),
    .capture_edge_sel(timer_ctrl_b_r[TMR16_B_EDGE]),
    .edge_pulse(cap_edge)
  );

  // ==========================================================
  // counter
  // ==========================================================
  assign wr_cnt = io_wr & (io_addr == TMR16_A_CNT_L);
  assign at_top = (counter_value_r == top_val);
  assign at_bottom = (counter_value_r == TMR16_BOTTOM);

  // next count and direction for one timer tick
  always_comb
  begin
    counter_value_nxt = counter_value_r;
    dir_nxt = dir_r;
    case (dir_r)
      TMR16_DIR_UP:
      begin
        if (at_top && phase_mode)
        begin
          dir_nxt = TMR16_DIR_DOWN;
          counter_value_nxt = counter_value_r - TMR16_ONE;
        end
        else if (at_top)
          counter_value_nxt = TMR16_BOTTOM;
        else
          counter_value_nxt = counter_value_r + TMR16_ONE;
      end
      TMR16_DIR_DOWN:
      begin
        if (at_bottom)
        begin
          dir_nxt = TMR16_DIR_UP;
          counter_value_nxt = counter_value_r + TMR16_ONE;
        end
        else
          counter_value_nxt = counter_value_r - TMR16_ONE;
      end
      default: dir_nxt = TMR16_DIR_UP;
    endcase
  end

  // low-byte write moves latch and data together
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      counter_value_r <= TMR16_BOTTOM;
      dir_r <= TMR16_DIR_UP;
    end
    else if (wr_cnt)
      counter_value_r <= {temp_r, io_wdata};
    else if (tick)
    begin
      counter_value_r <= counter_value_nxt;
      dir_r <= phase_mode ? dir_nxt : TMR16_DIR_UP;
    end
  end

  // counter write blocks the next tick's match
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      block_cmp_r <= 1'b0;
    else if (wr_cnt)
      block_cmp_r <= 1'b1;
    else if (tick)
      block_cmp_r <= 1'b0;
  end

  // ==========================================================
  // compare and capture events
  // ==========================================================
  // continuous equality compare
  assign match_a = tick & ~block_cmp_r & (counter_value_r == compare_a_value_r);
  assign match_b = tick & ~block_cmp_r & (counter_value_r == compare_b_value_r);

  // overflow point depends on the mode
  assign ovf_evt = tick & (phase_mode ? (at_bottom && dir_r == TMR16_DIR_DOWN) :
                   fast_mode ? at_top : (counter_value_r == TMR16_MAX));

  // capture input disconnected while capture is top
  assign cap_evt = cap_edge & ~cap_is_top;

  // copy counter on capture, else cpu write
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      capture_value_r <= TMR16_BOTTOM;
    else if (cap_evt)
      capture_value_r <= counter_value_r;
    else if (io_wr && io_addr == TMR16_A_CAP_L)
      capture_value_r <= {temp_r, io_wdata};
  end

  // match pulses for the waveform unit, forced strobes included
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      compare_a_match_r <= 1'b0;
      compare_b_match_r <= 1'b0;
    end
    else
    begin
      compare_a_match_r <= match_a | force_compare_a;
      compare_b_match_r <= match_b | force_compare_b;
    end
  end

  // ==========================================================
  // flags: set wins over clear
  // ==========================================================
  always_comb
  begin
    flags_nxt = flags_r;
    if (io_wr && io_addr == TMR16_A_IRQ_FLG)
    begin
      if (io_wdata[TMR16_BIT_CAP]) flags_nxt.capture = 1'b0;
      if (io_wdata[TMR16_BIT_CMPA]) flags_nxt.compare_a = 1'b0;
      if (io_wdata[TMR16_BIT_CMPB]) flags_nxt.compare_b = 1'b0;
      if (io_wdata[TMR16_BIT_OVF]) flags_nxt.overflow = 1'b0;
    end
    if (irq_ack.capture) flags_nxt.capture = 1'b0;
    if (irq_ack.compare_a) flags_nxt.compare_a = 1'b0;
    if (irq_ack.compare_b) flags_nxt.compare_b = 1'b0;
    if (irq_ack.overflow) flags_nxt.overflow = 1'b0;
    // capture event, or top in capture-top modes
    if (cap_evt || (cap_is_top && tick && at_top && dir_r == TMR16_DIR_UP))
      flags_nxt.capture = 1'b1;
    // visible in the timer cycle after the match
    // forced strobes are not used here
    if (match_a) flags_nxt.compare_a = 1'b1;
    if (match_b) flags_nxt.compare_b = 1'b1;
    if (ovf_evt) flags_nxt.overflow = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  // request needs enable, global flag and status flag
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      irq_req_r <= '0;
    else
    begin
      irq_req_r.capture <= global_irq_en & timer_irq_enable_r[TMR16_BIT_CAP] & flags_nxt.capture;
      irq_req_r.compare_a <= global_irq_en & timer_irq_enable_r[TMR16_BIT_CMPA] &
                             flags_nxt.compare_a;
      irq_req_r.compare_b <= global_irq_en & timer_irq_enable_r[TMR16_BIT_CMPB] &
                             flags_nxt.compare_b;
      irq_req_r.overflow <= global_irq_en & timer_irq_enable_r[TMR16_BIT_OVF] &
                            flags_nxt.overflow;
    end
  end

  // ==========================================================
  // register writes
  // ==========================================================
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      timer_ctrl_b_r <= TMR16_CTRL_B_RST;
      timer_irq_enable_r <= 8'h00;
      compare_a_value_r <= TMR16_BOTTOM;
      compare_b_value_r <= TMR16_BOTTOM;
    end
    else if (io_wr)
    begin
      case (io_addr)
        TMR16_A_CTRL_B: timer_ctrl_b_r <= io_wdata & TMR16_CTRL_B_WMASK;
        TMR16_A_IRQ_EN: timer_irq_enable_r <= io_wdata;
        TMR16_A_CMPA_L: compare_a_value_r <= {temp_r, io_wdata};
        TMR16_A_CMPB_L: compare_b_value_r <= {temp_r, io_wdata};
        default: timer_ctrl_b_r <= timer_ctrl_b_r;
      endcase
    end
  end

  // shared high-byte latch: high write or low read fills it
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      temp_r <= 8'h00;
    else if (io_wr && (io_addr == TMR16_A_CNT_H || io_addr == TMR16_A_CMPA_H ||
             io_addr == TMR16_A_CMPB_H || io_addr == TMR16_A_CAP_H))
      temp_r <= io_wdata;
    else if (io_rd)
    begin
      case (io_addr)
        TMR16_A_CNT_L: temp_r <= counter_value_r[15:8];
        TMR16_A_CMPA_L: temp_r <= compare_a_value_r[15:8];
        TMR16_A_CMPB_L: temp_r <= compare_b_value_r[15:8];
        TMR16_A_CAP_L: temp_r <= capture_value_r[15:8];
        default: temp_r <= temp_r;
      endcase
    end
  end

  // ==========================================================
  // register reads
  // ==========================================================
  always_comb
  begin
    flags_rd = 8'h00;
    flags_rd[TMR16_BIT_CAP] = flags_r.capture;
    flags_rd[TMR16_BIT_CMPA] = flags_r.compare_a;
    flags_rd[TMR16_BIT_CMPB] = flags_r.compare_b;
    flags_rd[TMR16_BIT_OVF] = flags_r.overflow;
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      io_rdata_r <= 8'h00;
    else if (io_rd)
    begin
      case (io_addr)
        TMR16_A_CTRL_B: io_rdata_r <= timer_ctrl_b_r;
        TMR16_A_CNT_L: io_rdata_r <= counter_value_r[7:0];
        TMR16_A_CMPA_L: io_rdata_r <= compare_a_value_r[7:0];
        TMR16_A_CMPB_L: io_rdata_r <= compare_b_value_r[7:0];
        TMR16_A_CAP_L: io_rdata_r <= capture_value_r[7:0];
        TMR16_A_CNT_H, TMR16_A_CMPA_H, TMR16_A_CMPB_H, TMR16_A_CAP_H: io_rdata_r <= temp_r;
        TMR16_A_IRQ_EN: io_rdata_r <= timer_irq_enable_r;
        TMR16_A_IRQ_FLG: io_rdata_r <= flags_rd;
        default: io_rdata_r <= 8'h00;
      endcase
    end
  end

  assign io_rdata = io_rdata_r;
  assign irq_req = irq_req_r;
  assign compare_a_match = compare_a_match_r;
  assign compare_b_match = compare_b_match_r;

endmodule : tmr16_core

//--- tb/tmr16_core_chk.sv
`timescale 1ns/1ps
// ==========================================================
// port checker of the timer slice
// ==========================================================
module tmr16_core_chk
  import tmr16_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic global_irq_en,
  input wire logic force_compare_a,
  input wire tmr16_evt_s irq_req,
  input wire logic compare_a_match
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_irq_cap;
    irq_req.capture |-> $past(global_irq_en);
  endproperty
  a_irq_cap: assert property (p_irq_cap) else $error("capture request ungated");
  property p_irq_cmpa;
    $rose(irq_req.compare_a) |-> $past(global_irq_en);
  endproperty
  a_irq_cmpa: assert property (p_irq_cmpa) else $error("compare request ungated");
  property p_irq_ovf;
    !global_irq_en |=> !irq_req.overflow;
  endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request ungated");
  property p_force_a;
    force_compare_a |=> compare_a_match;
  endproperty
  a_force_a: assert property (p_force_a) else $error("forced match missing");
  property p_unmapped;
    (io_rd && (io_addr > TMR16_A_IRQ_FLG)) |=> (io_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_resv;
    (io_rd && (io_addr == TMR16_A_CTRL_B)) |=> !io_rdata[5];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_wr_blk;
    (io_wr && (io_addr == TMR16_A_CNT_L)) ##1 !force_compare_a |=> !compare_a_match;
  endproperty
  a_wr_blk: assert property (p_wr_blk) else $error("match after counter write");
endmodule : tmr16_core_chk

//--- tb/tmr16_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================
// processor side of the i/o register bus
// ==========================================================
module tmr16_cpu_model
  import tmr16_pkg::*;
(
  input wire logic mclk,
  output logic [3:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  // idle bus at time zero
  initial
  begin
    io_addr = 4'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // one strobe cycle, data inverted once released
  task automatic access(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    #1;
    io_addr = a;
    io_wr = w;
    io_rd = ~w;
    io_wdata = d;
    @(posedge mclk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask : access

  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    access(a, 1'b1, (a == TMR16_A_CTRL_B) ? (d & TMR16_CTRL_B_WMASK) : d);
  endtask : wr8

  task automatic rd8(input logic [3:0] a);
    access(a, 1'b0, io_wdata);
  endtask : rd8

  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr8(a + 4'h1, d[15:8]);
    wr8(a, d[7:0]);
  endtask : wr16
endmodule : tmr16_cpu_model

//--- tb/tb_tmr16_core.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench of the timer slice
// ==========================================================
module tb_tmr16_core
  import tmr16_pkg::*;
;
  typedef struct {
    string nm;
    logic [7:0] lo;
    logic [7:0] hi;
  } tmr16_exp_s;
  tmr16_exp_s exp_q[$];
  tmr16_exp_s e;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic rd_q = 1'b0;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic global_irq_en = 1'b0;
  tmr16_evt_s irq_ack = '0;
  tmr16_evt_s irq_req;
  logic force_compare_a = 1'b0;
  logic force_compare_b = 1'b0;
  logic ext_count_pin = 1'b0;
  logic capture_pin = 1'b0;
  logic comparator_out = 1'b0;
  logic use_comparator = 1'b0;
  logic compare_a_match;
  logic compare_b_match;
  logic [15:0] v;
  logic [15:0] cap_exp = 16'h0000;
  int seed = 27608;
  int miscompares = 0;
  int samples_checked = 0;
  int div_tbl [5] = '{1, 8, 64, 256, 1024};

  // free-running clock
  initial
  begin
    forever #4 mclk = ~mclk;
  end

  tmr16_core dut_u (
    .mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .wave_mode_lo(2'b00),
    .global_irq_en(global_irq_en), .irq_ack(irq_ack), .force_compare_a(force_compare_a),
    .force_compare_b(force_compare_b), .ext_count_pin(ext_count_pin),
    .capture_pin(capture_pin), .comparator_out(comparator_out),
    .use_comparator(use_comparator), .irq_req(irq_req),
    .compare_a_match(compare_a_match), .compare_b_match(compare_b_match)
  );
  tmr16_cpu_model cpu_u (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // compare read data against an allowed range
  task automatic cmp_range(input string nm, input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] seen);
    samples_checked++;
    if (((seen >= lo) && (seen <= hi)) !== 1'b1)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, seen);
    end
  endtask : cmp_range

  // compare the request outputs
  task automatic check_irq(input logic [3:0] x);
    samples_checked++;
    if (irq_req !== x)
    begin
      miscompares++;
      $display("[FAIL] irq_req expected %b seen %b", x, irq_req);
    end
  endtask : check_irq

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi,
    input string nm);
    exp_q.push_back('{nm, lo, hi});
    cpu_u.rd8(a);
  endtask : rd_exp

  // low byte first, high through the latch
  task automatic rd16_exp(input logic [3:0] a, input logic [15:0] x, input string nm);
    rd_exp(a, x[7:0], x[7:0], nm);
    rd_exp(a + 4'h1, x[15:8], x[15:8], nm);
  endtask : rd16_exp

  // one capture source change on a stopped counter, changed back after hold cycles when rev is set
  task automatic cap_step(input logic [7:0] ctrl, input logic lvl, input int hold,
    input logic rev, input logic hit);
    logic [15:0] cnt;
    cnt = 16'($random(seed));
    cpu_u.wr8(TMR16_A_IRQ_FLG, 8'hFF);
    cpu_u.wr8(TMR16_A_CTRL_B, ctrl);
    cpu_u.wr16(TMR16_A_CNT_L, cnt);
    if (use_comparator)
      comparator_out = lvl;
    else
      capture_pin = lvl;
    cyc(hold);
    if (rev && use_comparator)
      comparator_out = ~lvl;
    else if (rev)
      capture_pin = ~lvl;
    cyc(10);
    if (hit)
      cap_exp = cnt;
    rd16_exp(TMR16_A_CAP_L, cap_exp, "capture_value");
    rd_exp(TMR16_A_IRQ_FLG, {2'b00, hit, 5'h00}, {2'b00, hit, 5'h00}, "capture_flag");
    check_irq({hit, 3'b000});
  endtask : cap_step

  task automatic results();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // read data lands one cycle after the strobe; compare at the falling edge
  always @(posedge mclk) rd_q <= io_rd;
  always @(negedge mclk)
  begin
    if (rd_q && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      cmp_range(e.nm, e.lo, e.hi, io_rdata);
    end
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    $display("[FAIL] run expected end seen hang");
    results();
  end

  // main sequence
  initial
  begin
    cyc(12);
    rst_n = 1'b1;
    for (int a = 0; a < 16; a++)
      rd_exp(a[3:0], 8'h00, 8'h00, "reset value");
    cpu_u.wr8(TMR16_A_CTRL_B, 8'hFF);
    rd_exp(TMR16_A_CTRL_B, 8'hDF, 8'hDF, "timer_ctrl_b");
    cpu_u.wr8(TMR16_A_CTRL_B, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($random(seed));
      cpu_u.wr16(4'(1 + 2 * i), v);
      rd16_exp(4'(1 + 2 * i), v, "word");
    end
    cap_exp = v;
    $display("test registers done");
    for (int c = 1; c < 6; c++)
    begin
      cpu_u.wr16(TMR16_A_CNT_L, 16'h0000);
      cpu_u.wr8(TMR16_A_CTRL_B, 8'(c));
      cyc(8 * div_tbl[c - 1] - 2);
      cpu_u.wr8(TMR16_A_CTRL_B, 8'h00);
      rd_exp(TMR16_A_CNT_L, 8'h07, 8'h09, "rate count");
      rd_exp(TMR16_A_CNT_H, 8'h00, 8'h00, "rate count");
    end
    for (int c = 6; c < 8; c++)
    begin
      cpu_u.wr16(TMR16_A_CNT_L, 16'h0000);
      cpu_u.wr8(TMR16_A_CTRL_B, 8'(c));
      repeat (5)
      begin
        ext_count_pin = 1'b1;
        cyc(3);
        ext_count_pin = 1'b0;
        cyc(3);
      end
      cyc(6);
      cpu_u.wr8(TMR16_A_CTRL_B, 8'h00);
      rd16_exp(TMR16_A_CNT_L, 16'h0005, "pin count");
    end
    $display("test clock select done");
    // matches and overflow set flags and requests
    cpu_u.wr16(TMR16_A_CMPA_L, 16'hFFF8);
    cpu_u.wr16(TMR16_A_CMPB_L, 16'hFFFC);
    cpu_u.wr16(TMR16_A_CNT_L, 16'hFFF0);
    cpu_u.wr8(TMR16_A_IRQ_FLG, 8'hFF);
    cpu_u.wr8(TMR16_A_IRQ_EN, 8'h3C);
    global_irq_en = 1'b1;
    cpu_u.wr8(TMR16_A_CTRL_B, 8'h01);
    cyc(30);
    cpu_u.wr8(TMR16_A_CTRL_B, 8'h00);
    cpu_u.wr8(TMR16_A_IRQ_FLG, 8'h00);
    rd_exp(TMR16_A_IRQ_FLG, 8'h1C, 8'h1C, "timer_irq_flags");
    check_irq(4'b0111);
    global_irq_en = 1'b0;
    cyc(2);
    check_irq(4'b0000);
    global_irq_en = 1'b1;
    cpu_u.wr8(TMR16_A_IRQ_FLG, 8'h10);
    rd_exp(TMR16_A_IRQ_FLG, 8'h0C, 8'h0C, "timer_irq_flags");
    irq_ack = 4'b0011;
    cyc(1);
    irq_ack = '0;
    rd_exp(TMR16_A_IRQ_FLG, 8'h00, 8'h00, "timer_irq_flags");
    check_irq(4'b0000);
    // counter rewritten while running onto compare a
    cpu_u.wr16(TMR16_A_CNT_L, 16'h0100);
    cpu_u.wr8(TMR16_A_CTRL_B, 8'h01);
    cpu_u.wr16(TMR16_A_CNT_L, 16'hFFF8);
    cpu_u.wr8(TMR16_A_CTRL_B, 8'h00);
    rd_exp(TMR16_A_IRQ_FLG, 8'h00, 8'h00, "blocked match");
    force_compare_a = 1'b1;
    force_compare_b = 1'b1;
    cyc(1);
    force_compare_a = 1'b0;
    force_compare_b = 1'b0;
    cmp_range("force_match", 8'h03, 8'h03, {6'h00, compare_a_match, compare_b_match});
    rd_exp(TMR16_A_IRQ_FLG, 8'h00, 8'h00, "forced match");
    $display("test compare done");
    // capture edge, filter, source and top mode
    cap_step(8'h00, 1'b1, 20, 1'b0, 1'b0);
    cap_step(8'h00, 1'b0, 20, 1'b0, 1'b1);
    cap_step(8'h40, 1'b1, 20, 1'b0, 1'b1);
    cap_step(8'h80, 1'b0, 2, 1'b1, 1'b0);
    cap_step(8'h80, 1'b0, 20, 1'b0, 1'b1);
    use_comparator = 1'b1;
    cap_step(8'h40, 1'b1, 20, 1'b0, 1'b1);
    use_comparator = 1'b0;
    cap_step(8'h58, 1'b1, 20, 1'b0, 1'b0);
    cpu_u.wr16(TMR16_A_CAP_L, 16'h0010);
    cpu_u.wr16(TMR16_A_CNT_L, 16'h0000);
    cpu_u.wr8(TMR16_A_IRQ_FLG, 8'hFF);
    cpu_u.wr8(TMR16_A_CTRL_B, 8'h19);
    cyc(30);
    cpu_u.wr8(TMR16_A_CTRL_B, 8'h00);
    rd_exp(TMR16_A_IRQ_FLG, 8'h20, 8'h20, "top flag");
    $display("test capture done");
    for (int i = 0; i < 20 && exp_q.size() > 0; i++)
      cyc(1);
    if (exp_q.size() > 0)
    begin
      miscompares++;
      $display("[FAIL] read queue expected 0 seen %0d", exp_q.size());
    end
    results();
  end
endmodule : tb_tmr16_core

bind tmr16_core tmr16_core_chk chk_u (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr),
  .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .global_irq_en(global_irq_en),
  .force_compare_a(force_compare_a), .irq_req(irq_req), .compare_a_match(compare_a_match));
